// ==== src/fpb_pkg.sv ====
// Shared constants for the parallel flash bus-operation block
package fpb_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int STAT_W = 8;
   localparam int WR_FIFO_DEPTH = 16;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_RESET = 8'h80;
   localparam logic WAIT_DEASSERTED = 1'b1;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_PERIOD_NS = 10;
   localparam int RST_PULSE_MIN_NS = 100;
   // Least time rounds up to whole cycles
   localparam int RST_PULSE_CYC = (RST_PULSE_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int LINK_ALIVE_TIMEOUT_CYC = 32;
   localparam int CNT_W = 6;

   // ----------------------------------------------------------------
   // Bus operation states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      FPB_ST_RESET = 4'h1,
      FPB_ST_IDLE = 4'h2,
      FPB_ST_READ = 4'h4,
      FPB_ST_WRITE = 4'h8
   } fpb_state_type;

endpackage : fpb_pkg

// ==== src/fpb_sync.sv ====
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none
module fpb_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      meta <= d_i;
      q_o <= meta;
   end

endmodule : fpb_sync
`default_nettype wire

// ==== src/fpb_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fpb_fifo #(
   parameter int WIDTH = 40,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0] wr_ptr;
   logic [PW:0] rd_ptr;
   logic [PW:0] next_wr_ptr;
   logic [PW:0] next_rd_ptr;
   logic full;
   logic empty;
   logic push;
   logic pop;

   // Extra pointer bit tells full from empty
   assign empty = (wr_ptr == rd_ptr);
   assign full = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem[rd_ptr[PW-1:0]];
   assign push = in_valid_i && !full;
   assign pop = out_ready_i && !empty;

   // Pointer advance
   always_comb begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // Storage carries no reset; only written words are ever read
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr[PW-1:0]] <= in_data_i;
      end
   end

endmodule : fpb_fifo
`default_nettype wire

// ==== src/fpb_bus_ops.sv ====
// Bus-operation layer of a 16-bit parallel flash: pin decode, address latch, write capture, reset
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Read only with reset and write enable high, select and output enable low.
// - Address latch is transparent while address-valid is low.
// - Output enable low drives the selected word onto the data bus.
// - Asynchronous mode latches address at rising address-valid, else flows through.
// - Synchronous mode latches at first of rising address-valid or link clock edge.
// - Write address and data captured on first rising write enable or select.
// - Output enable high floats all data outputs and the wait output.
// - Deselected device is in standby with data outputs floating.
// - Deselecting during program or erase does not stop the operation.
// - After reset, asynchronous array-read mode and status value 0x80.
// - Reset powers down, floats outputs and shuts down running operations.
// - Reset during program or erase aborts it with no completion reported.
// - Reset with no operation running completes within the minimum pulse width.
module fpb_bus_ops (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic clk_link_i,
   input wire logic rst_n_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic address_valid_n_i,
   input wire logic [fpb_pkg::ADDR_W-1:0] addr_i,
   input wire logic [fpb_pkg::DATA_W-1:0] dq_i,
   output logic [fpb_pkg::DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   output logic wait_o,
   output logic wait_oe_o,
   output logic write_ready_o,
   output logic [fpb_pkg::ADDR_W-1:0] rd_addr_o,
   input wire logic [fpb_pkg::DATA_W-1:0] rd_data_i,
   input wire logic rd_status_sel_i,
   input wire logic wait_level_i,
   input wire logic sync_mode_load_i,
   input wire logic sync_mode_val_i,
   input wire logic status_load_i,
   input wire logic [fpb_pkg::STAT_W-1:0] status_data_i,
   output logic [fpb_pkg::STAT_W-1:0] status_o,
   input wire logic op_busy_i,
   output logic abort_o,
   output logic power_down_o,
   output logic reset_done_o,
   output logic sync_mode_o,
   output logic wr_valid_o,
   input wire logic wr_ready_i,
   output logic [fpb_pkg::ADDR_W-1:0] wr_addr_o,
   output logic [fpb_pkg::DATA_W-1:0] wr_data_o
);

   localparam int PIN_W = 5 + fpb_pkg::ADDR_W + fpb_pkg::DATA_W;
   localparam int WORD_W = fpb_pkg::ADDR_W + fpb_pkg::DATA_W;

   // ----------------------------------------------------------------
   // Pin synchronisers into the system domain
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] pin_sync;
   logic s_rst_n;
   logic s_ce_n;
   logic s_oe_n;
   logic s_we_n;
   logic s_adv_n;
   logic [fpb_pkg::ADDR_W-1:0] s_addr;
   logic [fpb_pkg::DATA_W-1:0] s_dq;

   fpb_sync #(.WIDTH(PIN_W)) u_pin_sync (
      .clk_i(clk_sys_i),
      .d_i({rst_n_i, ce_n_i, oe_n_i, we_n_i, address_valid_n_i, addr_i, dq_i}),
      .q_o(pin_sync)
   );

   assign {s_rst_n, s_ce_n, s_oe_n, s_we_n, s_adv_n, s_addr, s_dq} = pin_sync;

   // ----------------------------------------------------------------
   // Link clock domain: synchronous-mode address capture
   // ----------------------------------------------------------------
   logic [1:0] link_ctl;
   logic l_rst_n;
   logic l_sync_mode;
   logic [fpb_pkg::ADDR_W-1:0] link_addr;
   logic [fpb_pkg::ADDR_W-1:0] next_link_addr;
   logic link_cap_tgl;
   logic next_link_cap_tgl;
   logic link_cap_done;
   logic next_link_cap_done;
   logic link_alive_tgl;
   logic sync_mode;

   fpb_sync #(.WIDTH(2)) u_link_ctl_sync (
      .clk_i(clk_link_i),
      .d_i({rst_n_i, sync_mode}),
      .q_o(link_ctl)
   );

   assign {l_rst_n, l_sync_mode} = link_ctl;

   // Control pins are synchronous to the link clock and are sampled directly
   always_comb begin
      next_link_addr = link_addr;
      next_link_cap_tgl = link_cap_tgl;
      next_link_cap_done = link_cap_done;
      if (address_valid_n_i) begin
         next_link_cap_done = 1'b0;
      end else if (l_sync_mode && !link_cap_done && !ce_n_i && we_n_i && rst_n_i) begin
         next_link_addr = addr_i;
         next_link_cap_tgl = !link_cap_tgl;
         next_link_cap_done = 1'b1;
      end
   end

   // Address stays held until a new capture, which needs address-valid to cycle
   always_ff @(posedge clk_link_i) begin
      if (!l_rst_n) begin
         link_addr <= '0;
         link_cap_tgl <= 1'b0;
         link_cap_done <= 1'b0;
         link_alive_tgl <= 1'b0;
      end else begin
         link_addr <= next_link_addr;
         link_cap_tgl <= next_link_cap_tgl;
         link_cap_done <= next_link_cap_done;
         link_alive_tgl <= !link_alive_tgl;
      end
   end

   // ----------------------------------------------------------------
   // Link events into the system domain
   // ----------------------------------------------------------------
   logic [1:0] link_evt_sync;
   logic cap_tgl_s;
   logic alive_tgl_s;
   logic cap_tgl_prev;
   logic alive_tgl_prev;
   logic link_cap_evt;
   logic [fpb_pkg::CNT_W-1:0] alive_cnt;
   logic [fpb_pkg::CNT_W-1:0] next_alive_cnt;
   logic clk_running;

   fpb_sync #(.WIDTH(2)) u_link_evt_sync (
      .clk_i(clk_sys_i),
      .d_i({link_cap_tgl, link_alive_tgl}),
      .q_o(link_evt_sync)
   );

   assign {cap_tgl_s, alive_tgl_s} = link_evt_sync;
   assign link_cap_evt = cap_tgl_s != cap_tgl_prev;
   assign clk_running = alive_cnt < fpb_pkg::CNT_W'(fpb_pkg::LINK_ALIVE_TIMEOUT_CYC);

   // Link clock counts as running while its toggle keeps changing
   always_comb begin
      if (alive_tgl_s != alive_tgl_prev) begin
         next_alive_cnt = '0;
      end else if (clk_running) begin
         next_alive_cnt = alive_cnt + 1'b1;
      end else begin
         next_alive_cnt = alive_cnt;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         cap_tgl_prev <= 1'b0;
         alive_tgl_prev <= 1'b0;
         alive_cnt <= fpb_pkg::CNT_W'(fpb_pkg::LINK_ALIVE_TIMEOUT_CYC);
      end else begin
         cap_tgl_prev <= cap_tgl_s;
         alive_tgl_prev <= alive_tgl_s;
         alive_cnt <= next_alive_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Bus operation decode
   // ----------------------------------------------------------------
   fpb_pkg::fpb_state_type state;
   fpb_pkg::fpb_state_type next_state;
   logic ce_prev;
   logic we_prev;
   logic adv_prev;
   logic [fpb_pkg::CNT_W-1:0] rst_cnt;
   logic [fpb_pkg::CNT_W-1:0] next_rst_cnt;
   logic next_abort;
   logic next_reset_done;
   logic push;
   logic fifo_in_ready;
   logic rd_cond;
   logic wr_cond;
   logic wr_end;

   assign rd_cond = s_rst_n && !s_ce_n && !s_oe_n && s_we_n;
   // Write pattern; keeping it legal is the host's part
   assign wr_cond = s_rst_n && !s_ce_n && !s_we_n && s_oe_n;
   // first rising edge of either strobe
   assign wr_end = (s_ce_n && !ce_prev) || (s_we_n && !we_prev);

   always_comb begin
      next_state = state;
      next_rst_cnt = rst_cnt;
      next_abort = 1'b0;
      next_reset_done = reset_done_o;
      push = 1'b0;
      if (!s_rst_n) begin
         next_state = fpb_pkg::FPB_ST_RESET;
         next_abort = (state != fpb_pkg::FPB_ST_RESET) && op_busy_i;
         if (state != fpb_pkg::FPB_ST_RESET) begin
            next_rst_cnt = '0;
            next_reset_done = 1'b0;
         end else if (rst_cnt < fpb_pkg::CNT_W'(fpb_pkg::RST_PULSE_CYC)) begin
            next_rst_cnt = rst_cnt + 1'b1;
         end
         // reset done within pulse width when idle
         if ((next_rst_cnt >= fpb_pkg::CNT_W'(fpb_pkg::RST_PULSE_CYC)) && !op_busy_i) begin
            next_reset_done = 1'b1;
         end
      end else begin
         case (state)
            fpb_pkg::FPB_ST_RESET: begin
               next_state = fpb_pkg::FPB_ST_IDLE;
               next_reset_done = 1'b1;
            end
            fpb_pkg::FPB_ST_IDLE: begin
               if (wr_cond) begin
                  next_state = fpb_pkg::FPB_ST_WRITE;
               end else if (rd_cond) begin
                  next_state = fpb_pkg::FPB_ST_READ;
               end
            end
            fpb_pkg::FPB_ST_READ: begin
               if (!rd_cond) begin
                  next_state = fpb_pkg::FPB_ST_IDLE;
               end
            end
            fpb_pkg::FPB_ST_WRITE: begin
               // capture once, then wait for idle
               if (wr_end) begin
                  push = 1'b1;
                  next_state = fpb_pkg::FPB_ST_IDLE;
               end
            end
            default: begin
               next_state = fpb_pkg::FPB_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state <= fpb_pkg::FPB_ST_RESET;
         rst_cnt <= '0;
         abort_o <= 1'b0;
         reset_done_o <= 1'b0;
         ce_prev <= 1'b1;
         we_prev <= 1'b1;
         adv_prev <= 1'b1;
      end else begin
         state <= next_state;
         rst_cnt <= next_rst_cnt;
         abort_o <= next_abort;
         reset_done_o <= next_reset_done;
         ce_prev <= s_ce_n;
         we_prev <= s_we_n;
         adv_prev <= s_adv_n;
      end
   end

   // ----------------------------------------------------------------
   // Mode, status and address latch
   // ----------------------------------------------------------------
   logic next_sync_mode;
   logic [fpb_pkg::STAT_W-1:0] status;
   logic [fpb_pkg::STAT_W-1:0] next_status;
   logic [fpb_pkg::ADDR_W-1:0] addr_lat;
   logic [fpb_pkg::ADDR_W-1:0] next_addr_lat;
   logic addr_held;
   logic next_addr_held;

   always_comb begin
      next_sync_mode = sync_mode;
      next_status = status;
      next_addr_lat = addr_lat;
      next_addr_held = addr_held;
      if (!s_rst_n) begin
         // asynchronous array read and status value on reset
         next_sync_mode = 1'b0;
         next_status = fpb_pkg::STATUS_RESET;
         next_addr_held = 1'b0;
      end else begin
         if (sync_mode_load_i) begin
            next_sync_mode = sync_mode_val_i;
         end
         if (status_load_i) begin
            next_status = status_data_i;
         end
         if (!s_adv_n && adv_prev) begin
            next_addr_held = 1'b0;
         end
         if (!sync_mode) begin
            // last value held after the rising edge
            if (!s_adv_n) begin
               next_addr_lat = s_addr;
            end
         end else if (!addr_held || (!s_adv_n && adv_prev)) begin
            // first of clock capture or rising address-valid wins
            if (link_cap_evt && !s_adv_n) begin
               next_addr_lat = link_addr;
               next_addr_held = 1'b1;
            end else if (!s_adv_n) begin
               next_addr_lat = s_addr;
            end else if (!adv_prev) begin
               next_addr_held = 1'b1;
            end
         end
      end
   end

   // Reset value of status comes from the pin; system reset gives the same
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         sync_mode <= 1'b0;
         status <= fpb_pkg::STATUS_RESET;
         addr_lat <= '0;
         addr_held <= 1'b0;
      end else begin
         sync_mode <= next_sync_mode;
         status <= next_status;
         addr_lat <= next_addr_lat;
         addr_held <= next_addr_held;
      end
   end

   assign status_o = status;
   assign sync_mode_o = sync_mode;
   assign rd_addr_o = addr_lat;
   // internal circuits powered down while reset is held
   assign power_down_o = (state == fpb_pkg::FPB_ST_RESET);
   // ongoing operations are not touched by standby, only by reset
   assign write_ready_o = fifo_in_ready && s_rst_n;

   // ----------------------------------------------------------------
   // Pin output drivers
   // ----------------------------------------------------------------
   logic [fpb_pkg::DATA_W-1:0] next_dq;
   logic next_dq_oe;
   logic next_wait;
   logic next_wait_oe;

   always_comb begin
      next_dq = dq_o;
      next_dq_oe = 1'b0;
      next_wait = fpb_pkg::WAIT_DEASSERTED;
      next_wait_oe = 1'b0;
      // output enable high floats data and wait
      if (rd_cond && (state == fpb_pkg::FPB_ST_READ)) begin
         next_dq_oe = 1'b1;
         next_dq = rd_status_sel_i ? fpb_pkg::DATA_W'(status) : rd_data_i;
         // wait driven or deasserted by mode
         next_wait_oe = 1'b1;
         if (sync_mode && clk_running) begin
            next_wait = wait_level_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         dq_o <= '0;
         dq_oe_o <= 1'b0;
         wait_o <= fpb_pkg::WAIT_DEASSERTED;
         wait_oe_o <= 1'b0;
      end else begin
         dq_o <= next_dq;
         dq_oe_o <= next_dq_oe;
         wait_o <= next_wait;
         wait_oe_o <= next_wait_oe;
      end
   end

   // ----------------------------------------------------------------
   // Captured write words towards the command core
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] fifo_out;

   // Words written while full are lost; the host must watch write_ready_o
   fpb_fifo #(.WIDTH(WORD_W), .DEPTH(fpb_pkg::WR_FIFO_DEPTH)) u_wr_fifo (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .in_data_i({addr_lat, s_dq}),
      .out_valid_o(wr_valid_o),
      .out_ready_i(wr_ready_i),
      .out_data_o(fifo_out)
   );

   assign {wr_addr_o, wr_data_o} = fifo_out;

endmodule : fpb_bus_ops
`default_nettype wire

// ==== testbench/fpb_bus_ops_asserts.sv ====
// Concurrent checks on the ports of the flash bus-operation block
`timescale 1ns/1ps
`default_nettype none
module fpb_bus_ops_asserts (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic rst_n_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic address_valid_n_i,
   input wire logic [fpb_pkg::ADDR_W-1:0] addr_i,
   input wire logic [fpb_pkg::DATA_W-1:0] dq_o,
   input wire logic dq_oe_o,
   input wire logic wait_o,
   input wire logic wait_oe_o,
   input wire logic [fpb_pkg::ADDR_W-1:0] rd_addr_o,
   input wire logic [fpb_pkg::DATA_W-1:0] rd_data_i,
   input wire logic rd_status_sel_i,
   input wire logic [fpb_pkg::STAT_W-1:0] status_o,
   input wire logic sync_mode_o,
   input wire logic op_busy_i,
   input wire logic abort_o,
   input wire logic power_down_o,
   input wire logic reset_done_o
);
   // --------
   // Helpers
   // --------
   logic [4:0] quiet_cnt;
   logic [4:0] next_quiet_cnt;
   // Length of a reset pulse with no program or erase running, saturating
   always_comb begin
      next_quiet_cnt = quiet_cnt;
      if (sys_rst_i || rst_n_i || op_busy_i) begin
         next_quiet_cnt = 5'h00;
      end else if (quiet_cnt != 5'h1f) begin
         next_quiet_cnt = quiet_cnt + 5'h01;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      quiet_cnt <= next_quiet_cnt;
   end
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   // Windows long enough to cover the two-stage pin synchronisers
   sequence s_read;
      (rst_n_i && !ce_n_i && !oe_n_i && we_n_i)[*8];
   endsequence
   sequence s_word;
      (rst_n_i && !ce_n_i && !oe_n_i && we_n_i && !rd_status_sel_i && $stable(rd_data_i))[*8];
   endsequence
   // --------
   // Checks
   // --------
   a_read_drive: assert property (s_read |-> dq_oe_o)
      else $error("data bus not driven in read");
   a_read_word: assert property (s_word |-> dq_o == rd_data_i)
      else $error("read word not on data bus");
   a_read_wait: assert property (s_read |-> wait_oe_o && (sync_mode_o || wait_o))
      else $error("wait wrong in read");
   a_oe_float: assert property (oe_n_i[*6] |-> !dq_oe_o && !wait_oe_o)
      else $error("outputs driven with output enable high");
   a_standby_float: assert property (ce_n_i[*6] |-> !dq_oe_o)
      else $error("data driven while deselected");
   a_reset_float: assert property (!rst_n_i[*6] |-> !dq_oe_o && !wait_oe_o && power_down_o)
      else $error("outputs live in reset");
   a_reset_state: assert property (!rst_n_i[*5] |-> status_o == fpb_pkg::STATUS_RESET && !sync_mode_o)
      else $error("status or mode not reset");
   a_abort_pulse: assert property (abort_o |=> !abort_o)
      else $error("abort longer than one cycle");
   a_async_follow: assert property ((rst_n_i && !sync_mode_o && !address_valid_n_i && $stable(addr_i))[*6]
      |-> rd_addr_o == addr_i)
      else $error("address latch not transparent");
   a_async_hold: assert property ((rst_n_i && !sync_mode_o && address_valid_n_i)[*6] |=> $stable(rd_addr_o))
      else $error("latched address moved");
   a_quiet_reset: assert property (quiet_cnt >= 5'h0e |-> reset_done_o)
      else $error("quiet reset not done in time");
endmodule : fpb_bus_ops_asserts
`default_nettype wire

// ==== testbench/fpb_host_model.sv ====
// Host model that drives the flash control, address and data pins
`timescale 1ns/1ps
`default_nettype none
module fpb_host_model (
   input wire logic clk_sys_i,
   output logic clk_link_o,
   output logic rst_n_o,
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic address_valid_n_o,
   output logic [23:0] addr_o,
   output logic [15:0] dq_o
);
   logic link_run;
   // Bus clock runs through power-on reset so the link logic starts known, then only in synchronous frames
   initial begin
      link_run = 1'b1;
      clk_link_o = 1'b0;
      #3.3;
      forever begin
         #62.5;
         clk_link_o = link_run & ~clk_link_o;
      end
   end
   // Flash reset starts low with the system reset; address flows through
   initial begin
      rst_n_o = 1'b0;
      {ce_n_o, oe_n_o, we_n_o} = 3'h7;
      address_valid_n_o = 1'b0;
      addr_o = 24'h000000;
      dq_o = 16'h0000;
   end
   task automatic bus(input logic ce, input logic oe, input logic we, input logic adv, input logic [23:0] a,
                      input int n);
      @(posedge clk_sys_i);
      {ce_n_o, oe_n_o, we_n_o} <= {ce, oe, we};
      address_valid_n_o <= adv;
      addr_o <= a;
      repeat (n - 1) @(posedge clk_sys_i);
   endtask : bus
   // data held past the first rise, then released to its inverse
   task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic ce_first);
      dq_o <= d;
      bus(1'b0, 1'b1, 1'b0, 1'b0, a, 5);
      bus(ce_first, 1'b1, ~ce_first, 1'b0, a, 3);
      bus(1'b1, 1'b1, 1'b1, 1'b0, a, 1);
      dq_o <= ~d;
      bus(1'b1, 1'b1, 1'b1, 1'b0, a, 4);
   endtask : wr
   // reset pin level, driven and then held for n cycles whichever way it goes
   task automatic rst(input logic v, input int n);
      @(posedge clk_sys_i);
      rst_n_o <= v;
      repeat (n - 1) @(posedge clk_sys_i);
   endtask : rst
endmodule : fpb_host_model
`default_nettype wire

// ==== testbench/fpb_bus_ops_tb.sv ====
// Self-checking bench for the flash bus-operation block
`timescale 1ns/1ps
`default_nettype none
module fpb_bus_ops_tb;
   logic clk_sys_i, sys_rst_i, clk_link_i, rst_n_i, ce_n_i, oe_n_i, we_n_i, address_valid_n_i;
   logic dq_oe_o, wait_o, wait_oe_o, write_ready_o, rd_status_sel_i, wait_level_i, sync_mode_load_i;
   logic sync_mode_val_i, status_load_i, op_busy_i, abort_o, power_down_o, reset_done_o, sync_mode_o;
   logic wr_valid_o, wr_ready_i, drain;
   logic [23:0] addr_i, rd_addr_o, wr_addr_o, a, b;
   logic [15:0] dq_i, dq_o, rd_data_i, wr_data_o;
   logic [7:0] status_data_i, status_o;
   logic [39:0] exp_q[$];
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int seed = 19;
   int abort_n = 0;
   // Array contents seen by the core side
   assign rd_data_i = rd_addr_o[15:0] ^ 16'h5a3c;
   fpb_bus_ops dut (.clk_sys_i, .sys_rst_i, .clk_link_i, .rst_n_i, .ce_n_i, .oe_n_i, .we_n_i,
      .address_valid_n_i, .addr_i, .dq_i, .dq_o, .dq_oe_o, .wait_o, .wait_oe_o, .write_ready_o, .rd_addr_o,
      .rd_data_i, .rd_status_sel_i, .wait_level_i, .sync_mode_load_i, .sync_mode_val_i, .status_load_i,
      .status_data_i, .status_o, .op_busy_i, .abort_o, .power_down_o, .reset_done_o, .sync_mode_o,
      .wr_valid_o, .wr_ready_i, .wr_addr_o, .wr_data_o);
   fpb_host_model host (.clk_sys_i, .clk_link_o(clk_link_i), .rst_n_o(rst_n_i), .ce_n_o(ce_n_i),
      .oe_n_o(oe_n_i), .we_n_o(we_n_i), .address_valid_n_o(address_valid_n_i), .addr_o(addr_i), .dq_o(dq_i));
   function automatic logic [15:0] word_of(input logic [23:0] x);
      return x[15:0] ^ 16'h5a3c;
   endfunction : word_of
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic complete_run();
      if (fail_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic wr(input logic [23:0] x, input logic [15:0] d);
      if (exp_q.size() < 16) exp_q.push_back({x, d});
      host.wr(x, d, d[0]);
   endtask : wr
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Core side pops write words with random stalls; hang guard
   always @(posedge clk_sys_i) begin
      cyc++;
      if (abort_o === 1'b1) abort_n++;
      if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1)
         chk({wr_addr_o, wr_data_o}, exp_q.size() ? exp_q.pop_front() : ~{wr_addr_o, wr_data_o});
      wr_ready_i <= drain && ($random(seed) % 2 != 0);
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   // --------
   // Main sequence
   // --------
   initial begin
      {sys_rst_i, drain, wr_ready_i, op_busy_i} = 4'h8;
      {rd_status_sel_i, wait_level_i, sync_mode_load_i, sync_mode_val_i, status_load_i} = 5'h00;
      status_data_i = 8'h00;
      repeat (4) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      drain <= 1'b1;
      host.rst(1'b0, 32);
      host.rst(1'b1, 20);
      host.link_run = 1'b0;
      chk({reset_done_o, status_o}, {1'b1, fpb_pkg::STATUS_RESET});
      // Random array reads, each followed by output disable
      for (int i = 0; i < 6; i++) begin
         a = 24'($random(seed));
         host.bus(1'b0, 1'b0, 1'b1, 1'b0, a, 10);
         chk(dq_o, word_of(a));
         chk({dq_oe_o, wait_oe_o, wait_o}, 3'h7);
         host.bus(1'b0, 1'b1, 1'b1, 1'b0, a, 6);
         chk({dq_oe_o, wait_oe_o}, 2'h0);
      end
      host.bus(1'b0, 1'b0, 1'b1, 1'b0, a, 10);
      rd_status_sel_i <= 1'b1;
      host.bus(1'b0, 1'b0, 1'b1, 1'b0, a, 4);
      chk(dq_o[7:0], fpb_pkg::STATUS_RESET);
      rd_status_sel_i <= 1'b0;
      host.bus(1'b1, 1'b0, 1'b1, 1'b0, a, 8);
      chk(dq_oe_o, 1'b0);
      // Address held after the rise of address-valid
      b = ~a;
      host.bus(1'b0, 1'b0, 1'b1, 1'b0, a, 6);
      host.bus(1'b0, 1'b0, 1'b1, 1'b1, a, 4);
      host.bus(1'b0, 1'b0, 1'b1, 1'b1, b, 6);
      chk(rd_addr_o, a);
      host.bus(1'b1, 1'b1, 1'b1, 1'b0, b, 4);
      // Writes draining, then a fill past the buffer depth
      for (int i = 0; i < 6; i++) wr(24'($random(seed)), 16'($random(seed)));
      drain <= 1'b0;
      for (int i = 0; i < 18; i++) wr(24'($random(seed)), 16'($random(seed)));
      chk(write_ready_o, 1'b0);
      drain <= 1'b1;
      host.bus(1'b1, 1'b1, 1'b1, 1'b0, b, 100);
      chk(exp_q.size(), 0);
      // Synchronous read with the bus clock running
      {sync_mode_val_i, sync_mode_load_i} <= 2'h3;
      @(posedge clk_sys_i);
      sync_mode_load_i <= 1'b0;
      host.link_run = 1'b1;
      host.bus(1'b0, 1'b0, 1'b1, 1'b0, a, 40);
      chk({sync_mode_o, wait_oe_o, wait_o}, 3'h6);
      host.bus(1'b0, 1'b0, 1'b1, 1'b0, b, 8);
      chk(rd_addr_o, a);
      host.link_run = 1'b0;
      // Deselect and reset while a program runs
      {status_data_i, status_load_i, op_busy_i} <= {8'h01, 2'h3};
      @(posedge clk_sys_i);
      status_load_i <= 1'b0;
      host.bus(1'b1, 1'b1, 1'b1, 1'b0, b, 10);
      chk(abort_n, 0);
      host.rst(1'b0, 6);
      op_busy_i <= 1'b0;
      host.rst(1'b0, 16);
      chk(abort_n, 1);
      chk({power_down_o, reset_done_o, dq_oe_o, status_o}, {3'h6, fpb_pkg::STATUS_RESET});
      host.rst(1'b1, 20);
      chk(sync_mode_o, 1'b0);
      host.bus(1'b0, 1'b0, 1'b1, 1'b0, a, 10);
      chk(dq_o, word_of(a));
      complete_run();
   end
endmodule : fpb_bus_ops_tb
bind fpb_bus_ops fpb_bus_ops_asserts u_chk (.clk_sys_i, .sys_rst_i, .rst_n_i, .ce_n_i, .oe_n_i, .we_n_i,
   .address_valid_n_i, .addr_i, .dq_o, .dq_oe_o, .wait_o, .wait_oe_o, .rd_addr_o, .rd_data_i, .rd_status_sel_i,
   .status_o, .sync_mode_o, .op_busy_i, .abort_o, .power_down_o, .reset_done_o);
`default_nettype wire
